// *** rtl/qdb_pkg.sv ***
package qdb_pkg;
  // ****************************************************************
  // Word and channel layout
  // ****************************************************************
  localparam int unsigned DATA_W = 12;   // One parallel word per transfer
  localparam int unsigned CHAN_N = 4;    // Four channels behind one port
  localparam int unsigned SEL_W = 2;     // Two select lines
  localparam logic [11:0] RESET_CODE_MID = 12'h800;  // Mid-scale variant
  localparam logic [11:0] RESET_CODE_ZERO = 12'h000; // Zero-scale variant

  // ****************************************************************
  // Pin timing, in ns, and derived cycle counts at CORE_CLK
  // ****************************************************************
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned T_CS_READ_NS = 200;    // Chip select low for a read
  localparam int unsigned T_CS_WRITE_NS = 50;    // Chip select low for a write
  localparam int unsigned T_LOAD_LOW_NS = 50;    // Load line low width
  localparam int unsigned T_LOAD_SETUP_NS = 70;  // Load low to chip select low
  localparam int unsigned T_LOAD_HOLD_NS = 50;   // Load low after chip select high
  localparam int unsigned T_SETUP_NS = 10;       // Direction setup before select
  localparam int unsigned CYC_CS_READ = (T_CS_READ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CYC_CS_WRITE = (T_CS_WRITE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CYC_LOAD_LOW = (T_LOAD_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CYC_SETUP = (T_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CYC_LOAD_GAP =
    (T_LOAD_SETUP_NS + T_LOAD_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] CYC_W = 4'h4;  // Width of the phase counter

  // ****************************************************************
  // Controller states
  // ****************************************************************
  typedef enum logic [2:0] {
    QDB_IDLE,
    QDB_SETUP,
    QDB_STROBE,
    QDB_RELEASE,
    QDB_LOAD
  } qdb_state_t;
endpackage

// *** rtl/qdb_host.sv ***
`timescale 1ns/1ps
// Overview of operation
// - Load held low: outputs follow written inputs
// - Single channel: write input, then pulse load
// - Write inputs with load high, then pulse once
// - One 12-bit parallel word per transfer
// - Select codes 00..11 address channels A..D
// - Direction high reads, low writes
// - Bit 0 is LSB, straight binary
module qdb_host (
  input wire logic CORE_CLK,
  input wire logic RESET_N,
  input wire logic CLK_EN,
  input wire logic REQ_VALID,        // One-cycle request from user logic
  input wire logic REQ_READ,         // High for readback, low for write
  input wire logic REQ_LOAD,         // Pulse load line after a write
  input wire logic [1:0] REQ_CHAN,   // Channel 0..3 = A..D
  input wire logic [11:0] REQ_DATA,  // Write word
  input wire logic LOAD_HOLD,        // Keep load line low permanently
  input wire logic DEV_RESET_REQ,    // Drive device reset low while high
  output logic REQ_READY,
  output logic RSP_VALID,
  output logic [11:0] RSP_DATA,
  output logic CHIP_SEL_N,
  output logic READ_WRITE,
  output logic SELECT_HIGH_BIT,
  output logic SELECT_LOW_BIT,
  output logic LOAD_OUTPUTS_N,
  output logic DEV_RESET_N,
  output logic [11:0] DATA_BUS_OUT,
  output logic DATA_BUS_OE,
  input wire logic [11:0] DATA_BUS_IN
);

  // ****************************************************************
  // Reset release and pin input synchroniser
  // ****************************************************************
  logic rst_meta_ff;
  logic rst_n_ff;
  logic [11:0] bus_meta_ff;   // First stage, read only by second stage
  logic [11:0] bus_sync_ff;

  // Release reset through two flops so every process sees a clean edge
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      rst_meta_ff <= 1'b0;
      rst_n_ff <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_n_ff <= rst_meta_ff;
    end
  end

  // Readback bus comes from the device pins, so it is synchronised
  always_ff @(posedge CORE_CLK or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      bus_meta_ff <= 12'h000;
      bus_sync_ff <= 12'h000;
    end else if (CLK_EN) begin
      bus_meta_ff <= DATA_BUS_IN;
      bus_sync_ff <= bus_meta_ff;
    end
  end

  // ****************************************************************
  // Transfer sequencer
  // ****************************************************************
  qdb_pkg::qdb_state_t state_ff, nxt_state;
  logic [3:0] cnt_ff, nxt_cnt;         // Cycles left in the current phase
  logic read_ff, nxt_read;
  logic load_ff, nxt_load;             // Load pulse pending after write
  logic [1:0] chan_ff, nxt_chan;
  logic [11:0] wdata_ff, nxt_wdata;
  logic cs_n_ff, nxt_cs_n;
  logic oe_ff, nxt_oe;
  logic ldn_ff, nxt_ldn;
  logic rsp_valid_ff, nxt_rsp_valid;
  logic [11:0] rsp_data_ff, nxt_rsp_data;
  logic ready_ff, nxt_ready;
  logic dev_rst_n_ff, nxt_dev_rst_n;

  // Cycle count cut to the phase counter width
  function automatic logic [3:0] cyc4(input int unsigned c);
    cyc4 = c[3:0];
  endfunction

  // Next-state logic for the whole pin sequence
  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    nxt_read = read_ff;
    nxt_load = load_ff;
    nxt_chan = chan_ff;
    nxt_wdata = wdata_ff;
    nxt_cs_n = cs_n_ff;
    nxt_oe = oe_ff;
    // Load line idles high unless held; a stale low would leave outputs transparent
    nxt_ldn = LOAD_HOLD ? 1'b0 : 1'b1;
    nxt_rsp_valid = 1'b0;
    nxt_rsp_data = rsp_data_ff;
    nxt_ready = 1'b0;
    nxt_dev_rst_n = !DEV_RESET_REQ;
    unique case (state_ff)
      qdb_pkg::QDB_IDLE: begin
        nxt_ready = !DEV_RESET_REQ;
        // Requests wait while device reset is driven, so inputs never open across release
        if (REQ_VALID && ready_ff && !DEV_RESET_REQ) begin
          nxt_read = REQ_READ;
          nxt_load = REQ_LOAD && !REQ_READ;
          nxt_chan = REQ_CHAN;
          nxt_wdata = REQ_DATA;
          nxt_ready = 1'b0;
          nxt_cnt = cyc4(qdb_pkg::CYC_SETUP);
          nxt_state = qdb_pkg::QDB_SETUP;
        end
      end
      qdb_pkg::QDB_SETUP: begin
        // Address and direction stand before chip select falls
        nxt_oe = !read_ff;
        if (cnt_ff <= 4'h1) begin
          nxt_cs_n = 1'b0;
          nxt_cnt = read_ff ? cyc4(qdb_pkg::CYC_CS_READ) + 4'h2 : cyc4(qdb_pkg::CYC_CS_WRITE);
          nxt_state = qdb_pkg::QDB_STROBE;
        end else begin
          nxt_cnt = cnt_ff - 4'h1;
        end
      end
      qdb_pkg::QDB_STROBE: begin
        // Read holds extra cycles so the synchronised bus is valid
        if (cnt_ff <= 4'h1) begin
          nxt_cs_n = 1'b1;
          if (read_ff) begin
            nxt_rsp_valid = 1'b1;
            nxt_rsp_data = bus_sync_ff;
          end
          nxt_cnt = cyc4(qdb_pkg::CYC_LOAD_GAP);
          nxt_state = qdb_pkg::QDB_RELEASE;
        end else begin
          nxt_cnt = cnt_ff - 4'h1;
        end
      end
      qdb_pkg::QDB_RELEASE: begin
        // Drop bus drive after chip select; gap also covers load timing
        nxt_oe = 1'b0;
        if (cnt_ff <= 4'h1) begin
          if (load_ff) begin
            nxt_ldn = 1'b0;
            nxt_cnt = cyc4(qdb_pkg::CYC_LOAD_LOW);
            nxt_state = qdb_pkg::QDB_LOAD;
          end else begin
            nxt_state = qdb_pkg::QDB_IDLE;
          end
        end else begin
          nxt_cnt = cnt_ff - 4'h1;
        end
      end
      qdb_pkg::QDB_LOAD: begin
        // All channels update together on this single pulse
        if (cnt_ff <= 4'h1) begin
          nxt_ldn = LOAD_HOLD ? 1'b0 : 1'b1;
          nxt_load = 1'b0;
          nxt_state = qdb_pkg::QDB_IDLE;
        end else begin
          // Keep the pulse low until its count runs out
          nxt_ldn = 1'b0;
          nxt_cnt = cnt_ff - 4'h1;
        end
      end
    endcase
  end

  // Registers only; clock enable freezes everything
  always_ff @(posedge CORE_CLK or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      state_ff <= qdb_pkg::QDB_IDLE;
      cnt_ff <= 4'h0;
      read_ff <= 1'b0;
      load_ff <= 1'b0;
      chan_ff <= 2'h0;
      wdata_ff <= 12'h000;
      cs_n_ff <= 1'b1;
      oe_ff <= 1'b0;
      ldn_ff <= 1'b1;
      rsp_valid_ff <= 1'b0;
      rsp_data_ff <= 12'h000;
      ready_ff <= 1'b0;
      dev_rst_n_ff <= 1'b0;
    end else if (CLK_EN) begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      read_ff <= nxt_read;
      load_ff <= nxt_load;
      chan_ff <= nxt_chan;
      wdata_ff <= nxt_wdata;
      cs_n_ff <= nxt_cs_n;
      oe_ff <= nxt_oe;
      ldn_ff <= nxt_ldn;
      rsp_valid_ff <= nxt_rsp_valid;
      rsp_data_ff <= nxt_rsp_data;
      ready_ff <= nxt_ready;
      dev_rst_n_ff <= nxt_dev_rst_n;
    end
  end

  // ****************************************************************
  // Pin and user outputs, all straight from flops
  // ****************************************************************
  assign REQ_READY = ready_ff;
  assign RSP_VALID = rsp_valid_ff;
  assign RSP_DATA = rsp_data_ff;
  assign CHIP_SEL_N = cs_n_ff;
  assign READ_WRITE = read_ff;
  assign SELECT_HIGH_BIT = chan_ff[1];
  assign SELECT_LOW_BIT = chan_ff[0];
  assign LOAD_OUTPUTS_N = ldn_ff;
  assign DEV_RESET_N = dev_rst_n_ff;
  assign DATA_BUS_OUT = wdata_ff;
  assign DATA_BUS_OE = oe_ff;

endmodule

// *** tb/qdb_host_monitor.sv ***
`timescale 1ns/1ps
// ********
// Pin checks
// ********
module qdb_host_monitor (
  input wire logic CORE_CLK,
  input wire logic RESET_N,
  input wire logic CLK_EN,
  input wire logic LOAD_HOLD,
  input wire logic DEV_RESET_REQ,
  input wire logic REQ_READY,
  input wire logic RSP_VALID,
  input wire logic CHIP_SEL_N,
  input wire logic READ_WRITE,
  input wire logic LOAD_OUTPUTS_N,
  input wire logic DEV_RESET_N,
  input wire logic DATA_BUS_OE
);
  // One clock domain
  default clocking cb @(posedge CORE_CLK);
  endclocking
  // A frozen clock enable stretches every phase, so timing checks pause with it
  default disable iff (!RESET_N || !CLK_EN);
  property p_dir; !CHIP_SEL_N |-> DATA_BUS_OE == !READ_WRITE; endproperty
  a_dir: assert property (p_dir) else $error("bus direction");
  property p_busy; !CHIP_SEL_N |-> !REQ_READY; endproperty
  a_busy: assert property (p_busy) else $error("ready in strobe");
  property p_wcs; $fell(CHIP_SEL_N) && !READ_WRITE |=> CHIP_SEL_N; endproperty
  a_wcs: assert property (p_wcs) else $error("write strobe width");
  property p_rcs; $fell(CHIP_SEL_N) && READ_WRITE |-> !CHIP_SEL_N [*4] ##1 CHIP_SEL_N; endproperty
  a_rcs: assert property (p_rcs) else $error("read strobe width");
  property p_rsp; $rose(CHIP_SEL_N) && READ_WRITE |-> RSP_VALID; endproperty
  a_rsp: assert property (p_rsp) else $error("no read word");
  // Load only well clear of the strobe, so the new word is settled
  property p_gap; $fell(LOAD_OUTPUTS_N) && !$past(LOAD_HOLD) |-> $past(CHIP_SEL_N, 2) && CHIP_SEL_N; endproperty
  a_gap: assert property (p_gap) else $error("load too close");
  property p_hold; LOAD_HOLD && $past(LOAD_HOLD) |-> !LOAD_OUTPUTS_N; endproperty
  a_hold: assert property (p_hold) else $error("load not held");
  property p_rst; DEV_RESET_REQ |=> !DEV_RESET_N; endproperty
  a_rst: assert property (p_rst) else $error("device reset");
endmodule
bind qdb_host qdb_host_monitor i_qdb_host_monitor (.CORE_CLK(CORE_CLK), .RESET_N(RESET_N), .CLK_EN(CLK_EN),
  .LOAD_HOLD(LOAD_HOLD), .DEV_RESET_REQ(DEV_RESET_REQ), .REQ_READY(REQ_READY), .RSP_VALID(RSP_VALID),
  .CHIP_SEL_N(CHIP_SEL_N), .READ_WRITE(READ_WRITE), .LOAD_OUTPUTS_N(LOAD_OUTPUTS_N),
  .DEV_RESET_N(DEV_RESET_N), .DATA_BUS_OE(DATA_BUS_OE));

// *** tb/qdb_dev_model.sv ***
`timescale 1ns/1ps
// ********
// Converter port, latches only
// ********
module qdb_dev_model #(
  parameter logic [11:0] RST_CODE = 12'h800
) (
  input wire logic cs_n,
  input wire logic rw,
  input wire logic [1:0] sel,
  input wire logic load_n,
  input wire logic rst_n,
  input wire logic [11:0] bus_in,
  output logic [11:0] rd_data,
  output logic rd_oe,
  output logic [47:0] codes
);
  logic [47:0] in_regs; // Channel A in the low word
  // Only the addressed input latch opens, and only in a write
  always_latch begin
    if (!rst_n) begin
      in_regs <= {4{RST_CODE}};
    end else if (!cs_n && !rw) begin
      in_regs[sel*12 +: 12] <= bus_in;
    end
  end
  // All output latches open together while load is low
  always_latch begin
    if (!rst_n) begin
      codes <= {4{RST_CODE}};
    end else if (!load_n) begin
      codes <= in_regs;
    end
  end
  assign rd_oe = !cs_n && rw;
  assign rd_data = in_regs[sel*12 +: 12];
endmodule

// *** tb/qdb_host_tb.sv ***
`timescale 1ns/1ps
// ********
// Host port bench
// ********
module qdb_host_tb;
  localparam logic [11:0] RST = qdb_pkg::RESET_CODE_MID; // Modelled variant
  localparam logic [11:0] W [4] = '{12'h001, 12'hFFE, 12'h5A5, 12'h7FF}; // Edge words
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic vld = 1'b0, rd = 1'b0, ld = 1'b0, hold = 1'b0, drq = 1'b0;
  logic en = 1'b1; // Clock enable, dropped only by the freeze scenario
  logic [1:0] ch = 2'h0;
  logic [11:0] wd = 12'h000;
  logic rdy, rv, cs_n, rw, sh, sl, ldn, drn, oe, doe;
  logic [11:0] rsp, bo, dq, bus;
  logic [47:0] codes;
  int n_mismatch = 0;
  int checked = 0;
  always #50 clk = ~clk;
  // Undriven bus flips every half cycle so a stale word never passes
  assign bus = oe ? bo : doe ? dq : ({12{clk}} ^ 12'hA5A);
  qdb_host i_qdb_host (.CORE_CLK(clk), .RESET_N(rst_n), .CLK_EN(en), .REQ_VALID(vld), .REQ_READ(rd),
    .REQ_LOAD(ld), .REQ_CHAN(ch), .REQ_DATA(wd), .LOAD_HOLD(hold), .DEV_RESET_REQ(drq), .REQ_READY(rdy),
    .RSP_VALID(rv), .RSP_DATA(rsp), .CHIP_SEL_N(cs_n), .READ_WRITE(rw), .SELECT_HIGH_BIT(sh),
    .SELECT_LOW_BIT(sl), .LOAD_OUTPUTS_N(ldn), .DEV_RESET_N(drn), .DATA_BUS_OUT(bo), .DATA_BUS_OE(oe),
    .DATA_BUS_IN(bus));
  qdb_dev_model #(.RST_CODE(RST)) i_qdb_dev_model (.cs_n(cs_n), .rw(rw), .sel({sh, sl}), .load_n(ldn),
    .rst_n(drn), .bus_in(bus), .rd_data(dq), .rd_oe(doe), .codes(codes));
  task automatic end_sim();
    $display("checked %0d n_mismatch %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [11:0] exp, input logic [11:0] got);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Bounded wait for idle
  task automatic wait_rdy();
    for (int i = 0; i < 50 && rdy !== 1'b1; i++) @(posedge clk);
    if (rdy !== 1'b1) begin
      chk("ready", 12'h001, 12'h000);
      end_sim();
    end
  endtask
  task automatic xfer(input logic r, input logic l, input logic [1:0] c, input logic [11:0] d);
    wait_rdy();
    vld <= 1'b1;
    rd <= r;
    ld <= l;
    ch <= c;
    wd <= d;
    @(posedge clk);
    vld <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [1:0] c, input logic [11:0] d, input logic l);
    xfer(1'b0, l, c, d);
    wait_rdy();
  endtask
  task automatic rdc(input logic [1:0] c, input logic [11:0] e);
    xfer(1'b1, 1'b0, c, 12'h000);
    for (int i = 0; i < 20 && rv !== 1'b1; i++) @(posedge clk);
    // A missing pulse must not pass on a stale word
    if (rv !== 1'b1) begin
      chk("read valid", 12'h001, 12'h000);
      end_sim();
    end
    chk("readback", e, rsp);
  endtask
  task automatic t_reset();
    for (int i = 0; i < 4; i++) chk("reset code", RST, codes[i*12 +: 12]);
    rdc(2'h3, RST);
  endtask
  // Outputs hold while inputs change; one load moves all
  task automatic t_buf();
    for (int i = 0; i < 3; i++) wr(i[1:0], W[i], 1'b0);
    for (int i = 0; i < 4; i++) chk("held", RST, codes[i*12 +: 12]);
    wr(2'h3, W[3], 1'b1);
    for (int i = 0; i < 4; i++) chk("loaded", W[i], codes[i*12 +: 12]);
    for (int i = 0; i < 4; i++) rdc(i[1:0], W[i]);
  endtask
  task automatic t_one();
    wr(2'h1, 12'hABC, 1'b1);
    for (int i = 0; i < 4; i++) chk("single", (i == 1) ? 12'hABC : W[i], codes[i*12 +: 12]);
  endtask
  task automatic t_hold();
    hold <= 1'b1;
    repeat (2) @(posedge clk);
    wr(2'h2, 12'h3C3, 1'b0);
    chk("transparent", 12'h3C3, codes[24 +: 12]);
    hold <= 1'b0;
    // Once released, the load line must latch outputs again
    wr(2'h2, 12'h111, 1'b0);
    chk("latched", 12'h3C3, codes[24 +: 12]);
  endtask
  // Clock enable low must freeze the strobe mid-write
  task automatic t_freeze();
    xfer(1'b0, 1'b0, 2'h0, 12'h0F0);
    en <= 1'b0;
    repeat (3) @(posedge clk);
    chk("frozen strobe", 12'h000, {11'h000, cs_n});
    en <= 1'b1;
    wait_rdy();
    rdc(2'h0, 12'h0F0);
  endtask
  task automatic t_drst();
    drq <= 1'b1;
    repeat (3) @(posedge clk);
    drq <= 1'b0;
    for (int i = 0; i < 4; i++) chk("device reset", RST, codes[i*12 +: 12]);
    rdc(2'h2, RST);
  endtask
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_buf();
    t_one();
    t_hold();
    t_drst();
    t_freeze();
    end_sim();
  end
endmodule
